// [otf_fault_ctrl.sv]
// over-temperature fault detection, response sequencing and its registers
`timescale 1ns/1ps

module otf_fault_ctrl
  import otf_pkg::*;
#(
  parameter int HOLD_CYC  = HOLD_UNIT_CYC,  // cycles per 80 ms unit
  parameter int RETRY_CYC = RETRY_UNIT_CYC  // cycles per 32 ms unit
) (
  input  wire logic        mclk,                 // core clock, 25 MHz
  input  wire logic        nrst,                 // async reset, active low
  input  wire logic        lnk_clk,              // command link clock
  input  wire logic        cmd_valid,            // command offered
  output logic             cmd_ready,            // command port idle
  input  wire logic        cmd_write,            // 1 write, 0 read
  input  wire logic [7:0]  cmd_code,             // command code
  input  wire logic [15:0] cmd_wdata,            // write word
  output logic             rsp_valid,            // answer pulse
  output logic             rsp_nack,             // unknown code
  output logic [15:0]      rsp_rdata,            // read word
  input  wire logic [15:0] temp_meas,            // temperature, linear
  input  wire logic        out_on_req,           // output wanted on
  input  wire logic        other_fault,          // other fault shutdown
  input  wire logic        fault_clear,          // clear-faults pulse
  output logic             out_enable,           // regulator output on
  output logic             ot_fault_status,      // sticky fault bit
  input  wire logic        fault_alert_line_in,  // alert wire level
  output logic             fault_alert_line_out, // alert drive value
  output logic             fault_alert_line_oe   // alert pulled low
);

  // ----------------------------------------------------------------------
  // link port and crossing
  // ----------------------------------------------------------------------
  otf_xfer_if xif ();

  otf_link_port u_link (
    .lnk_clk   (lnk_clk),
    .nrst      (nrst),
    .cmd_valid (cmd_valid),
    .cmd_ready (cmd_ready),
    .cmd_write (cmd_write),
    .cmd_code  (cmd_code),
    .cmd_wdata (cmd_wdata),
    .rsp_valid (rsp_valid),
    .rsp_nack  (rsp_nack),
    .rsp_rdata (rsp_rdata),
    .xif       (xif.link)
  );

  logic        req_s1_reg;
  logic        req_s2_reg;
  logic        req_s3_reg;
  logic        ack_reg;
  logic        nack_reg;
  logic [15:0] rdata_reg;
  logic [15:0] thr_reg;
  logic [7:0]  act_reg;

  // code, data and write flag are held steady by the link side until ack
  wire         req_seen = req_s2_reg ^ req_s3_reg;
  wire         hit_thr  = xif.code == CMD_OT_THR;
  wire         hit_act  = xif.code == CMD_OT_ACT;
  wire         unmapped = ~hit_thr & ~hit_act;
  wire         wr_thr   = req_seen & xif.wr & hit_thr;
  wire         wr_act   = req_seen & xif.wr & hit_act;
  wire  [15:0] rd_mux   = hit_thr ? thr_reg :
                          hit_act ? {8'h00, act_reg} : 16'h0000;

  assign xif.ack_tgl = ack_reg;
  assign xif.rdata   = rdata_reg;
  assign xif.nack    = nack_reg;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_s3_reg <= 1'b0;
    end else begin
      req_s1_reg <= xif.req_tgl;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
    end
  end

  // answer words are loaded in the same cycle the ack toggle is launched
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ack_reg   <= 1'b0;
      nack_reg  <= 1'b0;
      rdata_reg <= 16'h0000;
    end else if (req_seen) begin
      ack_reg   <= ~ack_reg;
      nack_reg  <= unmapped;
      rdata_reg <= xif.wr ? 16'h0000 : rd_mux;
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      thr_reg <= THR_RST;
    end else if (wr_thr) begin
      thr_reg <= xif.wdata;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      act_reg <= ACT_RST;
    end else if (wr_act) begin
      act_reg <= xif.wdata[7:0];
    end
  end

  wire  [1:0]  rsp_sel = act_reg[RSP_HI:RSP_LO];
  wire  [2:0]  rty_sel = act_reg[RTY_HI:RTY_LO];
  wire  [2:0]  dly_sel = act_reg[DLY_HI:DLY_LO];

  // ----------------------------------------------------------------------
  // temperature compare
  // ----------------------------------------------------------------------
  // both values are scaled to one fixed point so exponents may differ
  function automatic logic signed [FIX_W-1:0] lin_fix(
    input logic [15:0] v
  );
    logic signed [4:0]       n;
    logic signed [FIX_W-1:0] y;
    logic        [5:0]       sh;
    n  = v[LIN_EXP_HI:LIN_EXP_LO];
    y  = {{(FIX_W-LIN_MAN_HI-1){v[LIN_MAN_HI]}}, v[LIN_MAN_HI:0]};
    sh = 6'(int'(n) + LIN_BIAS);
    return y <<< sh;
  endfunction : lin_fix

  wire signed [FIX_W-1:0] temp_fix  = lin_fix(temp_meas);
  wire signed [FIX_W-1:0] thr_fix   = lin_fix(thr_reg);
  wire                    over_temp = temp_fix > thr_fix;

  logic fault_reg;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fault_reg <= 1'b0;
    end else begin
      fault_reg <= over_temp;
    end
  end

  // ----------------------------------------------------------------------
  // status bit and alert line
  // ----------------------------------------------------------------------
  logic status_reg;

  // a fault present in the clearing cycle keeps the bit set
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      status_reg <= 1'b0;
    end else if (fault_reg) begin
      status_reg <= 1'b1;
    end else if (fault_clear) begin
      status_reg <= 1'b0;
    end
  end

  assign ot_fault_status      = status_reg;
  assign fault_alert_line_out = 1'b0;
  assign fault_alert_line_oe  = status_reg;

  // ----------------------------------------------------------------------
  // delay timer
  // ----------------------------------------------------------------------
  logic tmr_start;
  logic tmr_retry;
  logic tmr_done;

  otf_unit_timer #(
    .HOLD_CYC  (HOLD_CYC),
    .RETRY_CYC (RETRY_CYC)
  ) u_tmr (
    .mclk      (mclk),
    .nrst      (nrst),
    .start     (tmr_start),
    .units     (dly_sel),
    .use_retry (tmr_retry),
    .done      (tmr_done)
  );

  // ----------------------------------------------------------------------
  // response sequencer
  // ----------------------------------------------------------------------
  otf_state_type state_reg;
  otf_state_type state_next;
  logic [2:0]    left_reg;
  logic [2:0]    left_next;
  logic          shut_now;
  logic          out_en_reg;

  // disabling the output or another fault ends any retry sequence
  wire           stop_retry = ~out_on_req | other_fault;
  wire           endless    = left_reg == RTY_FOREVER;

  always_comb begin
    state_next = state_reg;
    left_next  = left_reg;
    tmr_start  = 1'b0;
    tmr_retry  = 1'b0;
    shut_now   = 1'b0;
    unique case (state_reg)
      ST_RUN: begin
        if (fault_reg) begin
          unique case (rsp_sel)
            RSP_IGNORE: begin
              state_next = ST_RUN;
            end
            RSP_HOLD: begin
              tmr_start  = 1'b1;
              state_next = ST_HOLD;
            end
            RSP_DISABLE: begin
              shut_now = 1'b1;
            end
            RSP_UNTIL_CLR: begin
              state_next = ST_WAIT_CLR;
            end
          endcase
        end
      end
      ST_HOLD: begin
        if (tmr_done) begin
          if (fault_reg) begin
            shut_now = 1'b1;
          end else begin
            state_next = ST_RUN;
          end
        end
      end
      ST_SPACE: begin
        if (stop_retry) begin
          state_next = ST_LATCHED;
        end else if (tmr_done) begin
          if (!fault_reg) begin
            state_next = ST_RUN;
          end else if (endless) begin
            tmr_start = 1'b1;
            tmr_retry = 1'b1;
          end else if (left_reg == RTY_LAST) begin
            state_next = ST_LATCHED;
          end else begin
            left_next = left_reg - 3'h1;
            tmr_start = 1'b1;
            tmr_retry = 1'b1;
          end
        end
      end
      ST_LATCHED: begin
        if (fault_clear) begin
          state_next = ST_RUN;
        end
      end
      ST_WAIT_CLR: begin
        if (!fault_reg) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_LATCHED;
      end
    endcase
    if (shut_now) begin
      if (rty_sel == RTY_NONE) begin
        state_next = ST_LATCHED;
      end else begin
        left_next  = rty_sel;
        tmr_start  = 1'b1;
        tmr_retry  = 1'b1;
        state_next = ST_SPACE;
      end
    end
  end

  wire out_en_next = out_on_req &
                     ((state_next == ST_RUN) | (state_next == ST_HOLD));

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg  <= ST_RUN;
      left_reg   <= 3'h0;
      out_en_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      left_reg   <= left_next;
      out_en_reg <= out_en_next;
    end
  end

  assign out_enable = out_en_reg;

endmodule : otf_fault_ctrl

// [otf_fault_ctrl_properties.sv]
// port-level checks of the over-temperature fault response block
`timescale 1ns/1ps
module otf_fault_ctrl_properties
  import otf_pkg::*;
#(
  parameter int HOLD_CYC  = HOLD_UNIT_CYC,  // cycles per hold unit
  parameter int RETRY_CYC = RETRY_UNIT_CYC  // cycles per retry unit
) (
  input wire logic        mclk,                 // core clock
  input wire logic        nrst,                 // reset, active low
  input wire logic        lnk_clk,              // link clock
  input wire logic        cmd_valid,            // offer
  input wire logic        cmd_ready,            // idle
  input wire logic        cmd_write,            // write flag
  input wire logic [7:0]  cmd_code,             // code
  input wire logic [15:0] cmd_wdata,            // write word
  input wire logic        rsp_valid,            // answer
  input wire logic        out_on_req,           // output wanted
  input wire logic        other_fault,          // other fault
  input wire logic        fault_clear,          // clear pulse
  input wire logic        out_enable,           // output on
  input wire logic        ot_fault_status,      // fault bit
  input wire logic        fault_alert_line_out, // alert value
  input wire logic        fault_alert_line_oe   // alert drive
);
  // ----------------------------------------------------------------
  // shadow of the action byte and duration counters
  // ----------------------------------------------------------------
  logic [7:0]  act_sh;
  logic [15:0] hot_cnt;
  logic [15:0] off_cnt;
  wire  [1:0]  mode = act_sh[RSP_HI:RSP_LO];
  wire  [15:0] dly  = {13'h0000, act_sh[DLY_HI:DLY_LO]};

  // shadow leads the core by a few cycles; bench changes it only idle
  always_ff @(posedge lnk_clk or negedge nrst) begin
    if (!nrst)
      act_sh <= ACT_RST;
    else if (cmd_valid && cmd_ready && cmd_write && cmd_code == CMD_OT_ACT)
      act_sh <= cmd_wdata[7:0];
  end

  // off count saturates at reset so the first power-up is not a retry
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hot_cnt <= 16'h0000;
      off_cnt <= 16'hffff;
    end else begin
      hot_cnt <= !ot_fault_status ? 16'h0000
                 : hot_cnt + {15'h0000, hot_cnt != 16'hffff};
      off_cnt <= out_enable ? 16'h0000
                 : off_cnt + {15'h0000, off_cnt != 16'hffff};
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence taken_s;
    cmd_valid && cmd_ready;
  endsequence

  rsp_bound_a: assert property (@(posedge lnk_clk) disable iff (!nrst)
    taken_s |-> ##[3:12] rsp_valid)
    else $error("command answer missing");
  ready_busy_a: assert property (@(posedge lnk_clk) disable iff (!nrst)
    taken_s |=> !cmd_ready until rsp_valid)
    else $error("port idle before answer");
  alert_pull_a: assert property (@(posedge mclk) disable iff (!nrst)
    fault_alert_line_oe == ot_fault_status && !fault_alert_line_out)
    else $error("alert drive differs from fault bit");
  sticky_bit_a: assert property (@(posedge mclk) disable iff (!nrst)
    ot_fault_status && !fault_clear |=> ot_fault_status)
    else $error("fault bit dropped without clear");
  out_drop_a: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(out_enable) && $past(out_on_req) && !$past(other_fault)
    |-> ot_fault_status)
    else $error("output dropped without fault");
  ignore_keep_a: assert property (@(posedge mclk) disable iff (!nrst)
    mode == RSP_IGNORE && out_enable && out_on_req && !other_fault
    |=> out_enable)
    else $error("output interrupted in ignore mode");
  hold_time_a: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(out_enable) && mode == RSP_HOLD && $past(out_on_req)
    |-> hot_cnt >= dly * HOLD_CYC)
    else $error("output dropped before hold delay");
  spacing_a: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(out_enable) && (mode == RSP_HOLD || mode == RSP_DISABLE)
    |-> off_cnt >= dly * RETRY_CYC)
    else $error("restart before spacing elapsed");
  out_rise_a: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(out_enable) |-> $past(out_on_req) && !$past(other_fault))
    else $error("output on while disabled");
endmodule : otf_fault_ctrl_properties

bind otf_fault_ctrl otf_fault_ctrl_properties #(
  .HOLD_CYC (HOLD_CYC),
  .RETRY_CYC(RETRY_CYC)
) i_otf_fault_ctrl_properties (
  .mclk, .nrst, .lnk_clk, .cmd_valid, .cmd_ready, .cmd_write, .cmd_code,
  .cmd_wdata, .rsp_valid, .out_on_req, .other_fault, .fault_clear,
  .out_enable, .ot_fault_status, .fault_alert_line_out, .fault_alert_line_oe
);

// [otf_host_model.sv]
// link-side host model issuing word commands to the fault block
`timescale 1ns/1ps
module otf_host_model (
  input  wire logic        lnk_clk,   // link clock
  input  wire logic        cmd_ready, // port idle
  input  wire logic        rsp_valid, // answer pulse
  input  wire logic        rsp_nack,  // unknown code
  input  wire logic [15:0] rsp_rdata, // read word
  output logic             cmd_valid, // command offered
  output logic             cmd_write, // write flag
  output logic [7:0]       cmd_code,  // command code
  output logic [15:0]      cmd_wdata  // write word
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // idle code and data lines show the inverse so a stale value never looks valid
  task automatic xfer(input logic wr, input logic [7:0] c,
                      input logic [15:0] d, output logic [15:0] rd,
                      output logic nk);
    logic r;
    rd = 'x;
    nk = 1'b1;
    @(posedge lnk_clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_code  <= c;
    cmd_wdata <= d;
    do begin
      @(negedge lnk_clk);
      r = cmd_ready;
      @(posedge lnk_clk);
    end while (!r);
    cmd_valid <= 1'b0;
    cmd_code  <= ~c;
    cmd_wdata <= ~d;
    for (int n = 0; n < 16; n++) begin
      @(negedge lnk_clk);
      if (rsp_valid === 1'b1) begin
        rd = rsp_rdata;
        nk = rsp_nack;
        break;
      end
    end
  endtask : xfer
endmodule : otf_host_model

// [otf_link_port.sv]
// link-clock side of the command port: takes commands, returns answers
`timescale 1ns/1ps
module otf_link_port
  import otf_pkg::*;
(
  input  wire logic        lnk_clk,   // link clock
  input  wire logic        nrst,      // async reset, active low
  input  wire logic        cmd_valid, // command offered
  output logic             cmd_ready, // command port idle
  input  wire logic        cmd_write, // 1 write, 0 read
  input  wire logic [7:0]  cmd_code,  // command code
  input  wire logic [15:0] cmd_wdata, // write word
  output logic             rsp_valid, // answer pulse
  output logic             rsp_nack,  // unknown command code
  output logic [15:0]      rsp_rdata, // read word
  otf_xfer_if.link         xif        // toward core
);

  logic        busy_reg;
  logic        req_reg;
  logic        wr_reg;
  logic [7:0]  code_reg;
  logic [15:0] wdata_reg;
  logic        ack_s1_reg;
  logic        ack_s2_reg;
  logic        ack_s3_reg;
  logic        rv_reg;
  logic        nack_reg;
  logic [15:0] rdata_reg;
  wire         take     = cmd_valid & ~busy_reg;
  wire         ack_seen = ack_s2_reg ^ ack_s3_reg;

  assign cmd_ready   = ~busy_reg;
  assign rsp_valid   = rv_reg;
  assign rsp_nack    = nack_reg;
  assign rsp_rdata   = rdata_reg;
  assign xif.req_tgl = req_reg;
  assign xif.wr      = wr_reg;
  assign xif.code    = code_reg;
  assign xif.wdata   = wdata_reg;

  // command words stay put until the core acknowledges
  always_ff @(posedge lnk_clk or negedge nrst) begin
    if (!nrst) begin
      busy_reg  <= 1'b0;
      req_reg   <= 1'b0;
      wr_reg    <= 1'b0;
      code_reg  <= 8'h00;
      wdata_reg <= 16'h0000;
    end else if (take) begin
      busy_reg  <= 1'b1;
      req_reg   <= ~req_reg;
      wr_reg    <= cmd_write;
      code_reg  <= cmd_code;
      wdata_reg <= cmd_wdata;
    end else if (ack_seen) begin
      busy_reg  <= 1'b0;
    end
  end

  always_ff @(posedge lnk_clk or negedge nrst) begin
    if (!nrst) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      ack_s3_reg <= 1'b0;
      rv_reg     <= 1'b0;
      nack_reg   <= 1'b0;
      rdata_reg  <= 16'h0000;
    end else begin
      ack_s1_reg <= xif.ack_tgl;
      ack_s2_reg <= ack_s1_reg;
      ack_s3_reg <= ack_s2_reg;
      rv_reg     <= ack_seen;
      if (ack_seen) begin
        nack_reg  <= xif.nack;
        rdata_reg <= xif.rdata;
      end
    end
  end

endmodule : otf_link_port

// [otf_pkg.sv]
// shared constants and types for the over-temperature fault response block
package otf_pkg;

  // ----------------------------------------------------------------------
  // command codes and register reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  CMD_OT_THR     = 8'h4f;
  localparam logic [7:0]  CMD_OT_ACT     = 8'h50;
  localparam logic [15:0] THR_RST        = 16'h007d;
  localparam logic [7:0]  ACT_RST        = 8'h80;

  // ----------------------------------------------------------------------
  // action byte fields
  // ----------------------------------------------------------------------
  localparam int          RSP_HI         = 7;
  localparam int          RSP_LO         = 6;
  localparam int          RTY_HI         = 5;
  localparam int          RTY_LO         = 3;
  localparam int          DLY_HI         = 2;
  localparam int          DLY_LO         = 0;
  localparam logic [1:0]  RSP_IGNORE     = 2'h0;
  localparam logic [1:0]  RSP_HOLD       = 2'h1;
  localparam logic [1:0]  RSP_DISABLE    = 2'h2;
  localparam logic [1:0]  RSP_UNTIL_CLR  = 2'h3;
  localparam logic [2:0]  RTY_NONE       = 3'h0;
  localparam logic [2:0]  RTY_LAST       = 3'h1;
  localparam logic [2:0]  RTY_FOREVER    = 3'h7;

  // ----------------------------------------------------------------------
  // linear format layout
  // ----------------------------------------------------------------------
  localparam int          LIN_EXP_HI     = 15;
  localparam int          LIN_EXP_LO     = 11;
  localparam int          LIN_MAN_HI     = 10;
  localparam int          LIN_BIAS       = 16;
  localparam int          FIX_W          = 48;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int          CLK_KHZ        = 25000;
  localparam int          HOLD_UNIT_MS   = 80;
  localparam int          RETRY_UNIT_MS  = 32;
  localparam int          HOLD_UNIT_CYC  = HOLD_UNIT_MS * CLK_KHZ;
  localparam int          RETRY_UNIT_CYC = RETRY_UNIT_MS * CLK_KHZ;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_HOLD,
    ST_SPACE,
    ST_LATCHED,
    ST_WAIT_CLR
  } otf_state_type;

endpackage : otf_pkg

// [otf_unit_timer.sv]
// delay timer counting whole units of one of two lengths
`timescale 1ns/1ps
module otf_unit_timer
  import otf_pkg::*;
#(
  parameter int HOLD_CYC  = HOLD_UNIT_CYC,  // cycles per hold unit
  parameter int RETRY_CYC = RETRY_UNIT_CYC  // cycles per retry unit
) (
  input  wire logic       mclk,      // core clock
  input  wire logic       nrst,      // async reset, active low
  input  wire logic       start,     // restart the count
  input  wire logic [2:0] units,     // number of units
  input  wire logic       use_retry, // 1 retry unit, 0 hold unit
  output logic            done       // one-cycle pulse at expiry
);

  logic        run_reg;
  logic        sel_reg;
  logic [2:0]  left_reg;
  logic [31:0] tick_reg;
  logic        done_reg;
  wire  [31:0] lim_hold  = 32'(HOLD_CYC - 1);
  wire  [31:0] lim_retry = 32'(RETRY_CYC - 1);
  wire  [31:0] lim       = sel_reg ? lim_retry : lim_hold;
  wire         unit_end  = tick_reg == lim;

  assign done = done_reg;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      run_reg  <= 1'b0;
      sel_reg  <= 1'b0;
      left_reg <= 3'h0;
      tick_reg <= 32'h0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (start) begin
        run_reg  <= 1'b1;
        sel_reg  <= use_retry;
        left_reg <= units;
        tick_reg <= 32'h0;
      end else if (run_reg) begin
        if (left_reg == 3'h0) begin
          run_reg  <= 1'b0;
          done_reg <= 1'b1;
        end else if (unit_end) begin
          tick_reg <= 32'h0;
          left_reg <= left_reg - 3'h1;
        end else begin
          tick_reg <= tick_reg + 32'h1;
        end
      end
    end
  end

endmodule : otf_unit_timer

// [otf_xfer_if.sv]
// word handshake carried between the link port and the core
`timescale 1ns/1ps
interface otf_xfer_if;
  logic        req_tgl;
  logic        wr;
  logic [7:0]  code;
  logic [15:0] wdata;
  logic        ack_tgl;
  logic [15:0] rdata;
  logic        nack;

  modport link (
    output req_tgl, wr, code, wdata,
    input  ack_tgl, rdata, nack
  );
  modport core (
    input  req_tgl, wr, code, wdata,
    output ack_tgl, rdata, nack
  );
endinterface : otf_xfer_if

// [tb_top.sv]
// self-checking bench for the over-temperature fault response block
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
  $display("BAD %0t %h %h", $time, (a), (e)); end end
module tb_top
  import otf_pkg::*;
;
  // attempt to attempt for delay 1: one 8-cycle unit plus 2 timer cycles
  localparam int SP = 10;
  logic        mclk, lnk_clk, nrst, cmd_valid, cmd_ready, cmd_write;
  logic        rsp_valid, rsp_nack, out_on_req, other_fault, fault_clear;
  logic        out_enable, ot_fault_status, fault_alert_line_out;
  logic        fault_alert_line_oe, fault_alert_line_in, nk, hot;
  logic [7:0]  cmd_code, act;
  logic [15:0] cmd_wdata, rsp_rdata, temp_meas, rd, thrm;
  logic [31:0] seed;
  int          failures = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          y, r;

  initial mclk = 1'b0;
  initial lnk_clk = 1'b1;
  always #20 mclk = ~mclk;
  always #24 lnk_clk = ~lnk_clk;
  // open-drain alert wire with pull-up
  assign fault_alert_line_in = fault_alert_line_oe ? fault_alert_line_out
                                                   : 1'b1;

  otf_fault_ctrl #(.HOLD_CYC(20), .RETRY_CYC(8)) i_otf_fault_ctrl (
    .mclk, .nrst, .lnk_clk, .cmd_valid, .cmd_ready, .cmd_write, .cmd_code,
    .cmd_wdata, .rsp_valid, .rsp_nack, .rsp_rdata, .temp_meas, .out_on_req,
    .other_fault, .fault_clear, .out_enable, .ot_fault_status,
    .fault_alert_line_in, .fault_alert_line_out, .fault_alert_line_oe);
  otf_host_model i_otf_host_model (.lnk_clk, .cmd_ready, .rsp_valid,
    .rsp_nack, .rsp_rdata, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata);

  task automatic test_done();
    if (failures == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // ----------------------------------------------------------------
  // register model and link tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    i_otf_host_model.xfer(1'b1, c, d, rd, nk);
    if (c == CMD_OT_THR) thrm = d;
    if (c == CMD_OT_ACT) act = d[7:0];
    `CHK(nk, c != CMD_OT_THR && c != CMD_OT_ACT)
  endtask : wr

  task automatic rdc(input logic [7:0] c);
    logic [15:0] want;
    want = c == CMD_OT_THR ? thrm : c == CMD_OT_ACT ? {8'h00, act} : 16'h0000;
    i_otf_host_model.xfer(1'b0, c, 16'h0000, rd, nk);
    `CHK(rd, want)
    `CHK(nk, c != CMD_OT_THR && c != CMD_OT_ACT)
  endtask : rdc

  // ----------------------------------------------------------------
  // fault path tasks
  // ----------------------------------------------------------------
  task automatic tset(input int v);
    @(posedge mclk);
    temp_meas <= {5'h00, v[10:0]};
    hot = hot | (v > int'(thrm));
  endtask : tset

  task automatic wait_out(input logic e, input int n);
    repeat (n) begin
      @(negedge mclk);
      if (out_enable === e) break;
    end
    `CHK(out_enable, e)
  endtask : wait_out

  task automatic stay(input logic e, input int n);
    logic ok;
    ok = 1'b1;
    repeat (n) begin
      @(negedge mclk);
      if (out_enable !== e) ok = 1'b0;
    end
    `CHK(ok, 1'b1)
  endtask : stay

  task automatic heat();
    tset(200);
    repeat (3) @(negedge mclk);
    `CHK(ot_fault_status, 1'b1)
    `CHK(fault_alert_line_in, 1'b0)
  endtask : heat

  // needs a cool reading first; clear loses to a live fault
  task automatic recover();
    repeat (2) @(posedge mclk);
    fault_clear <= 1'b1;
    @(posedge mclk);
    fault_clear <= 1'b0;
    hot = 1'b0;
    wait_out(1'b1, 4);
    `CHK(ot_fault_status, 1'b0)
  endtask : recover

  initial begin
    nrst = 1'b0;
    out_on_req = 1'b1;
    other_fault = 1'b0;
    fault_clear = 1'b0;
    temp_meas = 16'h0014;
    seed = 32'h404b44b6;
    thrm = THR_RST;
    act = ACT_RST;
    hot = 1'b0;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    wait_out(1'b1, 4);
    rdc(CMD_OT_THR);
    rdc(CMD_OT_ACT);
    seed = lfsr(seed);
    wr(CMD_OT_THR, seed[15:0]);
    rdc(CMD_OT_THR);
    wr(CMD_OT_ACT, 16'hab3c);
    rdc(CMD_OT_ACT);
    wr(8'h51, 16'h1234);
    rdc(8'h51);
    wr(CMD_OT_THR, 16'h0064);
    recover();
    for (r = 0; r < 12; r++) begin
      seed = lfsr(seed);
      y = (r < 2) ? 100 + r : 95 + int'(seed[3:0]) % 10;
      tset(y);
      repeat (3) @(negedge mclk);
      `CHK(ot_fault_status, hot)
      `CHK(out_enable, 1'b1)
      if (hot) begin
        tset(20);
        recover();
      end
    end
    wr(CMD_OT_ACT, 16'h00c0);
    heat();
    stay(1'b0, 10);
    tset(20);
    wait_out(1'b1, 4);
    recover();
    wr(CMD_OT_ACT, 16'h0042);
    heat();
    stay(1'b1, 36);
    wait_out(1'b0, 10);
    tset(20);
    stay(1'b0, 30);
    recover();
    for (r = 0; r < 8; r++) begin
      for (y = 0; y < 2; y++) begin
        if (r == 0 && y == 1) continue;
        wr(CMD_OT_ACT, {8'h00, 2'h2, r[2:0], 3'h1});
        heat();
        wait_out(1'b0, 1);
        repeat ((r - y) * SP + 1) @(posedge mclk);
        tset(20);
        if (y == 1 || r == 7)
          wait_out(1'b1, SP + 4);
        else
          stay(1'b0, 2 * SP);
        recover();
      end
    end
    wr(CMD_OT_ACT, 16'h00b9);
    heat();
    @(posedge mclk);
    other_fault <= 1'b1;
    tset(20);
    stay(1'b0, 2 * SP);
    @(posedge mclk);
    other_fault <= 1'b0;
    recover();
    test_done();
  end
endmodule : tb_top
